// *** dv/sccc_host.sv ***
// host model driving single-byte register cycles
`timescale 1ns/10ps
`default_nettype none
module sccc_host (
    input  wire logic       clk_sys_i,
    input  wire logic [7:0] rdata_i,
    output var logic        wr_o,
    output var logic        rd_o,
    output var logic [5:0]  addr_o,
    output var logic [7:0]  wdata_o
);
    // ======
    // released address and data go inverted so a stale sample never matches
    initial begin
        {wr_o, rd_o, addr_o, wdata_o} = 16'h0000;
    end
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(negedge clk_sys_i);
        {wr_o, addr_o, wdata_o} = {1'b1, a, d};
        @(negedge clk_sys_i);
        {wr_o, addr_o, wdata_o} = {1'b0, ~a, ~d};
    endtask : wr
    task automatic rd(input logic [5:0] a, output logic [7:0] d);
        @(negedge clk_sys_i);
        {rd_o, addr_o} = {1'b1, a};
        @(negedge clk_sys_i);
        {rd_o, addr_o} = {1'b0, ~a};
        d = rdata_i;
    endtask : rd
    // start bit set by read-modify-write so the other fields survive
    task automatic rmw_start(input logic [5:0] a);
        logic [7:0] v;
        rd(a, v);
        wr(a, v | 8'h80);
    endtask : rmw_start
endmodule : sccc_host
`default_nettype wire

// *** dv/sccc_sva.sv ***
// assertions on the synthesizer control ports
`timescale 1ns/10ps
`default_nettype none
module sccc_sva
    import sccc_pkg::*;
(
    input wire logic         clk_sys_i,
    input wire logic         rstn_i,
    input wire logic         reg_wr_i,
    input wire logic         reg_rd_i,
    input wire logic [5:0]   reg_addr_i,
    input wire logic [7:0]   reg_wdata_i,
    input wire logic [7:0]   reg_rdata_o,
    input wire sccc_trx_type trx_state_i,
    input wire logic         tx_start_i,
    input wire logic         tx_ready_o,
    input wire logic         cal_active_o,
    input wire logic         lock_irq_o,
    input wire logic         unlock_irq_o
);
    // ======
    // single clock domain, so clock and reset are given once
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rstn_i);
    a_lock_drops_unlock: assert property ($rose(lock_irq_o) |-> !unlock_irq_o)
        else $error("lock left unlock set");
    a_unlock_drops_lock: assert property ($rose(unlock_irq_o) |-> !lock_irq_o)
        else $error("unlock left lock set");
    a_band_upper_zero: assert property (reg_rd_i && reg_addr_i == SCCC_ADDR_BAND |=> reg_rdata_o[7:4] == 4'h0)
        else $error("band upper bits set");
    a_unmapped_zero: assert property (reg_rd_i && reg_addr_i == 6'h3f |=> reg_rdata_o == 8'h00)
        else $error("unmapped read not zero");
    a_idle_start_bits: assert property (reg_rd_i && reg_addr_i[5:1] == 5'h0d && !cal_active_o |=> !reg_rdata_o[7])
        else $error("start bit set while idle");
    a_tx_not_early: assert property (tx_start_i |=> !tx_ready_o [*8])
        else $error("tx ready too early");
    a_shift_no_irq: assert property (tx_start_i |=> (!$rose(lock_irq_o) && !$rose(unlock_irq_o)) [*8])
        else $error("irq during shift");
    a_cal_unlocks: assert property (reg_wr_i && reg_addr_i == SCCC_ADDR_CF_CAL && reg_wdata_i[7]
        && trx_state_i == SCCC_SYNTH_ON |-> ##[1:8] unlock_irq_o) else $error("no unlock on cal start");
endmodule : sccc_sva
bind sccc_synth_ctrl sccc_sva chk (.clk_sys_i, .rstn_i, .reg_wr_i, .reg_rd_i, .reg_addr_i, .reg_wdata_i,
    .reg_rdata_o, .trx_state_i, .tx_start_i, .tx_ready_o, .cal_active_o, .lock_irq_o, .unlock_irq_o);
`default_nettype wire

// *** dv/tb_top.sv ***
// self-checking bench for the synthesizer control block
`timescale 1ns/10ps
`default_nettype none
module tb_top
    import sccc_pkg::*;
;
    logic clk_sys_i = 1'b0, rstn_i = 1'b0, tx_start_i = 1'b0, tx_done_i = 1'b0, pll_unlock_pin_i = 1'b0;
    logic reg_wr_i, reg_rd_i, freq_valid_o, cal_active_o, tx_ready_o, tx_abort_o, lock_irq_o, unlock_irq_o;
    logic [5:0] reg_addr_i;
    logic [7:0] reg_wdata_i, reg_rdata_o, rv;
    logic [12:0] synth_freq_hm_o;
    sccc_trx_type trx_state_i = SCCC_TRANSCEIVER_OFF_STATE;
    int n_mismatch = 0, checked = 0, k;
    sccc_host host (.clk_sys_i, .rdata_i(reg_rdata_o), .wr_o(reg_wr_i), .rd_o(reg_rd_i), .addr_o(reg_addr_i),
        .wdata_o(reg_wdata_i));
    sccc_synth_ctrl uut (.clk_sys_i, .rstn_i, .reg_wr_i, .reg_addr_i, .reg_wdata_i, .reg_rd_i, .reg_rdata_o,
        .trx_state_i, .tx_start_i, .tx_done_i, .cf_dir_up_i(1'b1), .cf_steps_i(2'h2), .pll_unlock_pin_i,
        .synth_freq_hm_o, .freq_valid_o, .synth_enable_o(), .synth_locked_o(), .cal_active_o, .tx_ready_o,
        .tx_abort_o, .rx_return_o(), .cf_value_o(), .lock_irq_o, .unlock_irq_o);
    // ======
    initial begin
        forever #5 clk_sys_i = ~clk_sys_i;
    end
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk
    task automatic stop_test;
        $display("mismatches %0d comparisons %0d", n_mismatch, checked);
        if (n_mismatch == 0 && checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : stop_test
    // bounded wait on lock (0), tx ready (1) or abort (2); running out ends the run
    task automatic wait_on(input int s, input int lim);
        int i;
        for (i = 0; i < lim; i++) begin
            @(negedge clk_sys_i);
            if ({lock_irq_o, tx_ready_o, tx_abort_o} >> (2 - s) & 3'h1) break;
        end
        if (i == lim) begin
            n_mismatch++;
            stop_test();
        end
    endtask : wait_on
    // settle one hop, then compare validity and, for valid settings, the carrier
    task automatic hop(input logic [5:0] a, input logic [7:0] d, input logic [12:0] e);
        host.wr(a, d);
        repeat (1150) @(negedge clk_sys_i);
        chk(16'(freq_valid_o), 16'(e != 13'h0000));
        if (e != 13'h0000) chk(16'(synth_freq_hm_o), 16'(e));
    endtask : hop
    initial begin
        repeat (12) @(negedge clk_sys_i);
        rstn_i = 1'b1;
        host.rd(SCCC_ADDR_PHY_CC, rv);
        chk(16'(rv), 16'(SCCC_RST_PHY_CC));
        host.wr(SCCC_ADDR_INDEX, 8'h5a);
        host.rd(SCCC_ADDR_INDEX, rv);
        chk(16'(rv), 16'h005a);
        host.wr(SCCC_ADDR_BAND, 8'hf0);
        host.rd(SCCC_ADDR_BAND, rv);
        chk(16'(rv), 16'h0000);
        // an unmapped offset reads as zero
        host.rd(6'h3f, rv);
        chk(16'(rv), 16'h0000);
        trx_state_i = SCCC_SYNTH_ON;
        wait_on(0, 8100);
        // index 0x5a stays ignored while the band field is zero
        for (k = 11; k <= 26; k++) begin
            hop(SCCC_ADDR_PHY_CC, 8'(32 + k), 13'(SCCC_STD_BASE_HM - SCCC_RX_OFFS_HM + 10 * (k - 11)));
            chk(16'({unlock_irq_o, lock_irq_o}), 16'h1);
        end
        hop(SCCC_ADDR_BAND, 8'h09, 13'h135a);
        hop(SCCC_ADDR_INDEX, 8'hba, 13'h13ba);
        hop(SCCC_ADDR_INDEX, 8'hbb, 13'h0000);
        hop(SCCC_ADDR_BAND, 8'h08, 13'h12bb);
        hop(SCCC_ADDR_INDEX, 8'h20, 13'h1220);
        hop(SCCC_ADDR_INDEX, 8'h1f, 13'h0000);
        hop(SCCC_ADDR_BAND, 8'h03, 13'h0000);
        hop(SCCC_ADDR_BAND, 8'h00, 13'h135c);
        host.rmw_start(SCCC_ADDR_CF_CAL);
        repeat (4) @(negedge clk_sys_i);
        chk(16'({cal_active_o, unlock_irq_o}), 16'h3);
        repeat (1490) @(negedge clk_sys_i);
        host.rd(SCCC_ADDR_CF_CAL, rv);
        chk(16'(rv[7]), 16'h1);
        repeat (200) @(negedge clk_sys_i);
        host.rd(SCCC_ADDR_CF_CAL, rv);
        // two upward steps from the reset value 0x7, start bit clear
        chk(16'({rv, lock_irq_o}), 16'h00b3);
        host.wr(SCCC_ADDR_DCU_CAL, 8'hff);
        host.rd(SCCC_ADDR_DCU_CAL, rv);
        chk(16'({rv[7], cal_active_o}), 16'h3);
        repeat (620) @(negedge clk_sys_i);
        host.rd(SCCC_ADDR_DCU_CAL, rv);
        chk(16'(rv), 16'h0078);
        tx_start_i = 1'b1;
        trx_state_i = SCCC_TX_BUSY;
        @(negedge clk_sys_i);
        tx_start_i = 1'b0;
        repeat (400) @(negedge clk_sys_i);
        // a detector pulse inside the shift window must stay silent
        pll_unlock_pin_i = 1'b1;
        repeat (400) @(negedge clk_sys_i);
        pll_unlock_pin_i = 1'b0;
        wait_on(1, 900);
        chk(16'({unlock_irq_o, synth_freq_hm_o}), 16'(SCCC_STD_BASE_HM + 13'd150));
        host.rd(SCCC_ADDR_IRQ_STATUS, rv);
        chk(16'({rv, lock_irq_o}), 16'h0002);
        // a finished transmission steps back down without a lock event
        tx_done_i = 1'b1;
        @(negedge clk_sys_i);
        tx_done_i = 1'b0;
        repeat (3210) @(negedge clk_sys_i);
        chk(16'({lock_irq_o, synth_freq_hm_o}), 16'(SCCC_STD_BASE_HM + 13'd146));
        pll_unlock_pin_i = 1'b1;
        wait_on(2, 20);
        chk(16'(unlock_irq_o), 16'h1);
        stop_test();
    end
endmodule : tb_top
`default_nettype wire

// *** rtl/sccc_freq_decode.sv ***
// frequency decoder from channel, band and index to half-MHz carrier
`timescale 1ns/10ps
`default_nettype none
module sccc_freq_decode
    import sccc_pkg::*;
(
    input  wire logic [4:0]  channel_i,
    input  wire logic [3:0]  alt_band_select_i,
    input  wire logic [7:0]  alt_frequency_index_i,
    output logic      [12:0] freq_hm_o,
    output logic             valid_o
);
    // ==========================================
    // decode; reserved bands fall back to the standard base frequency and flag invalid
    always_comb begin
        freq_hm_o = SCCC_STD_BASE_HM;
        valid_o   = 1'b0;
        case (alt_band_select_i)
            SCCC_BAND_STD: begin
                freq_hm_o = SCCC_STD_BASE_HM + 13'(({8'h00, channel_i} - 13'd11) * 13'd10);
                valid_o   = (channel_i >= SCCC_CH_FIRST) && (channel_i <= SCCC_CH_LAST);
            end
            SCCC_BAND_LOW: begin
                freq_hm_o = SCCC_LOW_BASE_HM + {5'h00, alt_frequency_index_i};
                valid_o   = alt_frequency_index_i >= SCCC_LOW_MIN_IDX;
            end
            SCCC_BAND_HIGH: begin
                freq_hm_o = SCCC_HIGH_BASE_HM + {5'h00, alt_frequency_index_i};
                valid_o   = alt_frequency_index_i <= SCCC_HIGH_MAX_IDX;
            end
            default: begin
                valid_o = 1'b0;
            end
        endcase
    end
endmodule : sccc_freq_decode
`default_nettype wire

// *** rtl/sccc_pkg.sv ***
// constants and types for the synthesizer channel and calibration control
package sccc_pkg;
    // ==========================================
    // register offsets
    localparam logic [5:0] SCCC_ADDR_IRQ_STATUS = 6'h0f;
    localparam logic [5:0] SCCC_ADDR_PHY_CC     = 6'h08;
    localparam logic [5:0] SCCC_ADDR_INDEX      = 6'h13;
    localparam logic [5:0] SCCC_ADDR_BAND       = 6'h14;
    localparam logic [5:0] SCCC_ADDR_CF_CAL     = 6'h1a;
    localparam logic [5:0] SCCC_ADDR_DCU_CAL    = 6'h1b;
    // ==========================================
    // reset values and field positions
    localparam logic [7:0] SCCC_RST_PHY_CC   = 8'h2b;
    localparam logic [7:0] SCCC_RST_CF_CAL   = 8'h57;
    localparam logic [7:0] SCCC_RST_DCU_CAL  = 8'h20;
    localparam int         SCCC_START_BIT    = 7;
    localparam int         SCCC_LOCK_BIT     = 0;
    localparam int         SCCC_UNLOCK_BIT   = 1;
    localparam logic [4:0] SCCC_CH_FIRST     = 5'h0b;
    localparam logic [4:0] SCCC_CH_LAST      = 5'h1a;
    localparam logic [3:0] SCCC_BAND_STD     = 4'h0;
    localparam logic [3:0] SCCC_BAND_LOW     = 4'h8;
    localparam logic [3:0] SCCC_BAND_HIGH    = 4'h9;
    localparam logic [7:0] SCCC_LOW_MIN_IDX  = 8'h20;
    localparam logic [7:0] SCCC_HIGH_MAX_IDX = 8'hba;
    // frequencies in half-MHz units
    localparam logic [12:0] SCCC_STD_BASE_HM  = 13'd4810;
    localparam logic [12:0] SCCC_LOW_BASE_HM  = 13'd4612;
    localparam logic [12:0] SCCC_HIGH_BASE_HM = 13'd4868;
    localparam logic [12:0] SCCC_RX_OFFS_HM   = 13'd4;
    // ==========================================
    // timing
    localparam int SCCC_CLK_MHZ     = 100;
    localparam int SCCC_T_ENABLE_US = 80;
    localparam int SCCC_T_SWITCH_US = 11;
    localparam int SCCC_T_RXTX_US   = 16;
    localparam int SCCC_T_TXRX_US   = 32;
    localparam int SCCC_T_CF_STEP_US = 8;
    localparam int SCCC_T_DCU_US    = 6;
    localparam int SCCC_CYC_ENABLE  = SCCC_T_ENABLE_US * SCCC_CLK_MHZ;
    localparam int SCCC_CYC_SWITCH  = SCCC_T_SWITCH_US * SCCC_CLK_MHZ;
    localparam int SCCC_CYC_RXTX    = SCCC_T_RXTX_US * SCCC_CLK_MHZ;
    localparam int SCCC_CYC_TXRX    = SCCC_T_TXRX_US * SCCC_CLK_MHZ;
    localparam int SCCC_CYC_CF_STEP = SCCC_T_CF_STEP_US * SCCC_CLK_MHZ;
    localparam int SCCC_CYC_DCU     = SCCC_T_DCU_US * SCCC_CLK_MHZ;
    localparam int SCCC_CF_MAX_STEPS = 3;
    // ==========================================
    // transceiver states as seen by this block
    typedef enum logic [3:0] {
        SCCC_TRANSCEIVER_OFF_STATE   = 4'h0,
        SCCC_SYNTH_ON  = 4'h1,
        SCCC_RX_LISTEN = 4'h2,
        SCCC_TX_BUSY   = 4'h3,
        SCCC_RX_BUSY   = 4'h4,
        SCCC_EXT_TX_IDLE = 4'h5,
        SCCC_EXT_RX_IDLE = 4'h6,
        SCCC_EXT_TX_BUSY = 4'h7,
        SCCC_EXT_RX_BUSY = 4'h8
    } sccc_trx_type;
    // synthesizer sequencer
    typedef enum logic [2:0] {
        SCCC_SY_IDLE   = 3'h0,
        SCCC_SY_ENABLE = 3'h1,
        SCCC_SY_SWITCH = 3'h2,
        SCCC_SY_LOCKED = 3'h3,
        SCCC_SY_STEP   = 3'h4
    } sccc_synth_type;
    // register write strobe
    typedef struct packed {
        logic       wr;
        logic [5:0] addr;
        logic [7:0] data;
    } sccc_wr_type;
    // lock status pair
    typedef struct packed {
        logic unlock;
        logic lock;
    } sccc_irq_type;
endpackage : sccc_pkg

// *** rtl/sccc_synth_ctrl.sv ***
// synthesizer channel, calibration and lock control, top level
`timescale 1ns/10ps
`default_nettype none
module sccc_synth_ctrl
    import sccc_pkg::*;
#(
    parameter int TW = 14
) (
    input  wire logic         clk_sys_i,
    input  wire logic         rstn_i,
    // register port from the spi engine, same clock
    input  wire logic         reg_wr_i,
    input  wire logic [5:0]   reg_addr_i,
    input  wire logic [7:0]   reg_wdata_i,
    input  wire logic         reg_rd_i,
    output logic      [7:0]   reg_rdata_o,
    // transceiver state and events
    input  wire sccc_trx_type trx_state_i,
    input  wire logic         tx_start_i,
    input  wire logic         tx_done_i,
    input  wire logic         cf_dir_up_i,
    input  wire logic [1:0]   cf_steps_i,
    input  wire logic         pll_unlock_pin_i,
    output logic      [12:0]  synth_freq_hm_o,
    output logic              freq_valid_o,
    output logic              synth_enable_o,
    output logic              synth_locked_o,
    output logic              cal_active_o,
    output logic              tx_ready_o,
    output logic              tx_abort_o,
    output logic              rx_return_o,
    output logic [3:0]        cf_value_o,
    output logic              lock_irq_o,
    output logic              unlock_irq_o
);
    // ==========================================
    // registers
    logic [7:0]   phy_cc_q, phy_cc_d, idx_q, idx_d, cf_q, cf_d, dcu_q, dcu_d, rdata_q, rdata_d;
    logic [3:0]   band_q, band_d;
    sccc_irq_type irq_q, irq_d;
    logic         dcu_run_q, dcu_run_d;
    logic [1:0]   cf_left_q, cf_left_d;
    logic         cf_manual_q, cf_manual_d;
    logic [12:0]  freq_q, freq_d;
    logic         fvalid_q, fvalid_d;
    logic         txhi_q, txhi_d, abort_q, abort_d, rxret_q, rxret_d, rxpend_q, rxpend_d;
    logic         ulk_s1_q, ulk_s2_q, ulk_s3_q;
    sccc_trx_type st_q;
    sccc_synth_type sy_q, sy_d;
    logic [12:0]  dec_freq;
    logic         dec_valid;
    logic         t_load, t_busy, t_done, d_load, d_done, x_load, x_busy, x_done;
    logic [TW-1:0] t_count, x_count;
    logic         powered, hop_state, tx_state, rx_busy, freq_change, cf_kick, dcu_kick, unlock_ev;
    sccc_wr_type  wr;

    assign wr = '{wr: reg_wr_i, addr: reg_addr_i, data: reg_wdata_i};

    // true in every state that keeps the synthesizer running
    function automatic logic is_powered(input sccc_trx_type s);
        return s != SCCC_TRANSCEIVER_OFF_STATE;
    endfunction

    // states where a hop may raise the unlock event
    function automatic logic is_hop_state(input sccc_trx_type s);
        return (s == SCCC_SYNTH_ON) || (s == SCCC_RX_LISTEN);
    endfunction

    // ==========================================
    // helpers
    sccc_freq_decode u_dec (
        .channel_i             (phy_cc_q[4:0]),
        .alt_band_select_i     (band_q),
        .alt_frequency_index_i (idx_q),
        .freq_hm_o             (dec_freq),
        .valid_o               (dec_valid)
    );

    sccc_timer #(.WIDTH(TW)) u_settle (
        .clk_sys_i (clk_sys_i),
        .rstn_i    (rstn_i),
        .load_i    (t_load),
        .count_i   (t_count),
        .busy_o    (t_busy),
        .done_o    (t_done)
    );

    sccc_timer #(.WIDTH(TW)) u_dcu (
        .clk_sys_i (clk_sys_i),
        .rstn_i    (rstn_i),
        .load_i    (d_load),
        .count_i   (TW'(SCCC_CYC_DCU)),
        .busy_o    (),
        .done_o    (d_done)
    );

    sccc_timer #(.WIDTH(TW)) u_txrx (
        .clk_sys_i (clk_sys_i),
        .rstn_i    (rstn_i),
        .load_i    (x_load),
        .count_i   (x_count),
        .busy_o    (x_busy),
        .done_o    (x_done)
    );

    // ==========================================
    // external unlock detector crosses in through two stages
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ulk_s1_q <= 1'b0;
            ulk_s2_q <= 1'b0;
            ulk_s3_q <= 1'b0;
            st_q     <= SCCC_TRANSCEIVER_OFF_STATE;
        end else begin
            ulk_s1_q <= pll_unlock_pin_i;
            ulk_s2_q <= ulk_s1_q;
            ulk_s3_q <= ulk_s2_q;
            st_q     <= trx_state_i;
        end
    end

    assign powered     = is_powered(trx_state_i);
    assign hop_state   = is_hop_state(trx_state_i);
    assign tx_state    = (trx_state_i == SCCC_TX_BUSY) || (trx_state_i == SCCC_EXT_TX_BUSY);
    assign rx_busy     = (trx_state_i == SCCC_RX_BUSY) || (trx_state_i == SCCC_EXT_RX_BUSY);
    assign freq_change = powered && is_powered(st_q) && (dec_freq != freq_q);
    assign cf_kick     = wr.wr && (wr.addr == SCCC_ADDR_CF_CAL) && wr.data[SCCC_START_BIT];
    assign dcu_kick    = wr.wr && (wr.addr == SCCC_ADDR_DCU_CAL) && wr.data[SCCC_START_BIT];
    // detector unlock is ignored while the rx/tx step settles
    assign unlock_ev   = ulk_s2_q && !ulk_s3_q && !x_busy && (sy_q == SCCC_SY_LOCKED);

    // ==========================================
    // synthesizer sequencer: enable, hop, manual center step
    always_comb begin
        sy_d        = sy_q;
        t_load      = 1'b0;
        t_count     = TW'(SCCC_CYC_ENABLE);
        cf_left_d   = cf_left_q;
        cf_manual_d = cf_manual_q;
        irq_d       = irq_q;
        freq_d      = freq_q;
        fvalid_d    = fvalid_q;
        d_load      = dcu_kick;
        // a status read clears both flags; an event further down in the same cycle still sets
        if (reg_rd_i && reg_addr_i == SCCC_ADDR_IRQ_STATUS) begin
            irq_d = '0;
        end
        if (!powered) begin
            sy_d = SCCC_SY_IDLE;
            cf_manual_d = 1'b0;
            cf_left_d = 2'd0;
        end else begin
            case (sy_q)
                SCCC_SY_IDLE: begin
                    sy_d = SCCC_SY_ENABLE;
                    t_load = 1'b1;
                    d_load = 1'b1;
                    freq_d = dec_freq;
                    fvalid_d = dec_valid;
                end
                SCCC_SY_ENABLE, SCCC_SY_SWITCH: begin
                    if (t_done) begin
                        sy_d = SCCC_SY_LOCKED;
                        irq_d = '{unlock: 1'b0, lock: 1'b1};
                    end
                end
                SCCC_SY_STEP: begin
                    if (t_done) begin
                        if (cf_left_q > 2'd1) begin
                            cf_left_d = cf_left_q - 2'd1;
                            t_load = 1'b1;
                            t_count = TW'(SCCC_CYC_CF_STEP);
                        end else begin
                            cf_left_d = 2'd0;
                            cf_manual_d = 1'b0;
                            sy_d = SCCC_SY_LOCKED;
                            irq_d = '{unlock: 1'b0, lock: 1'b1};
                        end
                    end
                end
                default: begin
                    sy_d = SCCC_SY_LOCKED;
                end
            endcase
            if (sy_q != SCCC_SY_IDLE && freq_change) begin
                sy_d = SCCC_SY_SWITCH;
                cf_manual_d = 1'b0; // a hop ends a manual step, or its start bit would stick
                t_load = 1'b1;
                t_count = TW'(SCCC_CYC_SWITCH);
                d_load = 1'b1;
                freq_d = dec_freq;
                fvalid_d = dec_valid;
                if (hop_state) begin
                    irq_d = '{unlock: 1'b1, lock: 1'b0};
                end
            end else if (sy_q != SCCC_SY_IDLE && cf_kick) begin
                sy_d = SCCC_SY_STEP;
                t_load = 1'b1;
                t_count = TW'(SCCC_CYC_CF_STEP);
                cf_manual_d = 1'b1;
                cf_left_d = (cf_steps_i == 2'd0) ? 2'd1 : cf_steps_i; // 1 to 3 steps, 8 to 24 us
                if (hop_state) begin
                    irq_d = '{unlock: 1'b1, lock: 1'b0};
                end
            end else if (unlock_ev) begin
                sy_d = SCCC_SY_SWITCH; // relock over a hop-sized window
                t_load = 1'b1;
                t_count = TW'(SCCC_CYC_SWITCH);
                irq_d = '{unlock: 1'b1, lock: 1'b0};
            end
        end
    end

    // ==========================================
    // rx/tx offset step and busy-state effects of lock changes
    always_comb begin
        txhi_d   = txhi_q;
        x_load   = 1'b0;
        x_count  = TW'(SCCC_CYC_RXTX);
        abort_d  = 1'b0;
        rxret_d  = 1'b0;
        rxpend_d = rxpend_q;
        if (tx_start_i && !txhi_q) begin
            txhi_d = 1'b1;
            x_load = 1'b1;
        end else if ((tx_done_i || abort_q) && txhi_q) begin
            txhi_d  = 1'b0;
            x_load  = 1'b1;
            x_count = TW'(SCCC_CYC_TXRX);
        end
        if (unlock_ev && tx_state) begin
            abort_d = 1'b1;
        end
        if (unlock_ev && rx_busy) begin
            rxpend_d = 1'b1;
        end else if (rxpend_q && sy_q == SCCC_SY_LOCKED) begin
            rxpend_d = 1'b0;
            rxret_d  = 1'b1;
        end
    end

    // ==========================================
    // register writes; start bits self-clear on completion
    always_comb begin
        phy_cc_d  = phy_cc_q;
        idx_d     = idx_q;
        band_d    = band_q;
        cf_d      = cf_q;
        dcu_d     = dcu_q;
        dcu_run_d = dcu_run_q;
        if (wr.wr) begin
            case (wr.addr)
                SCCC_ADDR_PHY_CC:  phy_cc_d = wr.data;
                SCCC_ADDR_INDEX:   idx_d = wr.data;
                SCCC_ADDR_BAND:    band_d = wr.data[3:0];
                SCCC_ADDR_CF_CAL:  cf_d = wr.data;
                SCCC_ADDR_DCU_CAL: dcu_d = wr.data;
                default:           phy_cc_d = phy_cc_q;
            endcase
        end
        if (dcu_kick || d_load) begin
            dcu_run_d = 1'b1;
        end else if (d_done) begin
            dcu_run_d = 1'b0;
        end
        // successive approximation leaves the result in the low bits
        if (d_done) begin
            dcu_d[3:0] = 4'h8;
        end
        if (sy_q == SCCC_SY_STEP && t_done) begin
            cf_d[3:0] = cf_up_step(cf_q[3:0], cf_dir_up_i);
        end
        cf_d[SCCC_START_BIT]  = cf_manual_d;
        dcu_d[SCCC_START_BIT] = dcu_run_d;
    end

    // one center-frequency step, saturating
    function automatic logic [3:0] cf_up_step(input logic [3:0] v, input logic up);
        if (up) begin
            return (v == 4'hf) ? v : v + 4'h1;
        end
        return (v == 4'h0) ? v : v - 4'h1;
    endfunction

    // ==========================================
    // read mux
    always_comb begin
        rdata_d = rdata_q;
        if (reg_rd_i) begin
            case (reg_addr_i)
                SCCC_ADDR_PHY_CC:     rdata_d = phy_cc_q;
                SCCC_ADDR_INDEX:      rdata_d = idx_q;
                SCCC_ADDR_BAND:       rdata_d = {4'h0, band_q};
                SCCC_ADDR_CF_CAL:     rdata_d = cf_q;
                SCCC_ADDR_DCU_CAL:    rdata_d = dcu_q;
                SCCC_ADDR_IRQ_STATUS: rdata_d = {6'h00, irq_q.unlock, irq_q.lock};
                default:              rdata_d = 8'h00;
            endcase
        end
    end

    // ==========================================
    // state registers
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            phy_cc_q    <= SCCC_RST_PHY_CC;
            idx_q       <= 8'h00;
            band_q      <= 4'h0;
            cf_q        <= SCCC_RST_CF_CAL;
            dcu_q       <= SCCC_RST_DCU_CAL;
            dcu_run_q   <= 1'b0;
            irq_q       <= '0;
            sy_q        <= SCCC_SY_IDLE;
            cf_left_q   <= 2'd0;
            cf_manual_q <= 1'b0;
            freq_q      <= SCCC_STD_BASE_HM;
            fvalid_q    <= 1'b0;
            txhi_q      <= 1'b0;
            abort_q     <= 1'b0;
            rxret_q     <= 1'b0;
            rxpend_q    <= 1'b0;
            rdata_q     <= 8'h00;
        end else begin
            phy_cc_q    <= phy_cc_d;
            idx_q       <= idx_d;
            band_q      <= band_d;
            cf_q        <= cf_d;
            dcu_q       <= dcu_d;
            dcu_run_q   <= dcu_run_d;
            irq_q       <= irq_d;
            sy_q        <= sy_d;
            cf_left_q   <= cf_left_d;
            cf_manual_q <= cf_manual_d;
            freq_q      <= freq_d;
            fvalid_q    <= fvalid_d;
            txhi_q      <= txhi_d;
            abort_q     <= abort_d;
            rxret_q     <= rxret_d;
            rxpend_q    <= rxpend_d;
            rdata_q     <= rdata_d;
        end
    end

    // ==========================================
    // outputs, all from flip-flops except the timer status
    assign synth_freq_hm_o = txhi_q ? freq_q : freq_q - SCCC_RX_OFFS_HM;
    assign freq_valid_o    = fvalid_q;
    assign synth_enable_o  = (sy_q != SCCC_SY_IDLE);
    assign synth_locked_o  = (sy_q == SCCC_SY_LOCKED);
    assign cal_active_o    = cf_q[SCCC_START_BIT] || dcu_q[SCCC_START_BIT];
    assign tx_ready_o      = txhi_q && !x_busy;
    assign tx_abort_o      = abort_q;
    assign rx_return_o     = rxret_q;
    assign cf_value_o      = cf_q[3:0];
    assign lock_irq_o      = irq_q.lock;
    assign unlock_irq_o    = irq_q.unlock;
    assign reg_rdata_o     = rdata_q;
endmodule : sccc_synth_ctrl
`default_nettype wire

// *** rtl/sccc_timer.sv ***
// reloadable down counter that pulses on expiry
`timescale 1ns/10ps
`default_nettype none
module sccc_timer #(
    parameter int WIDTH = 14
) (
    input  wire logic             clk_sys_i,
    input  wire logic             rstn_i,
    input  wire logic             load_i,
    input  wire logic [WIDTH-1:0] count_i,
    output logic                  busy_o,
    output logic                  done_o
);
    logic [WIDTH-1:0] cnt_q, cnt_d;
    logic             done_q, done_d;

    // ==========================================
    // a new load restarts the count even while busy
    always_comb begin
        cnt_d  = cnt_q;
        done_d = 1'b0;
        if (load_i) begin
            cnt_d = count_i;
        end else if (cnt_q != '0) begin
            cnt_d  = cnt_q - 1'b1;
            done_d = (cnt_q == WIDTH'(1));
        end
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cnt_q  <= '0;
            done_q <= 1'b0;
        end else begin
            cnt_q  <= cnt_d;
            done_q <= done_d;
        end
    end

    assign busy_o = (cnt_q != '0);
    assign done_o = done_q;
endmodule : sccc_timer
`default_nettype wire
